// *** rtl/spvq_map.svh ***
`ifndef SPVQ_MAP_SVH
`define SPVQ_MAP_SVH
// vector length and table selects
`define SPVQ_NEL        16
`define SPVQ_TBL_CB     2'h0
`define SPVQ_TBL_MEAN   2'h1
`define SPVQ_TBL_COS    2'h2
// split descriptors: book, first element, element count, index bits
`define SPVQ_P_S1A      16'h0098
`define SPVQ_P_S1V      16'h1098
`define SPVQ_P_S1B      16'h2978
`define SPVQ_P_FR0      16'h3036
`define SPVQ_P_FR1      16'h4337
`define SPVQ_P_FR2      16'h5637
`define SPVQ_P_FR3      16'h6935
`define SPVQ_P_FR4      16'h7C45
`define SPVQ_P_HR0      16'h8057
`define SPVQ_P_HR1      16'h9547
`define SPVQ_P_HR2      16'hA976
`define SPVQ_P_QR0      16'hB055
`define SPVQ_P_QR1      16'hC545
`define SPVQ_P_QR2      16'hD976
`define SPVQ_NPART_FR   3'h7
`define SPVQ_NPART_SPL  3'h5
// q15 coefficients
`define SPVQ_MA_COEF    17'h02AAB
`define SPVQ_AR_COEF    17'h05333
`define SPVQ_INV_SCALE  17'h06666
`define SPVQ_SCALE_SHR  2
`define SPVQ_Q15_ONE    17'h08000
`define SPVQ_W_SF0      17'h02000
`define SPVQ_W_SF1      17'h04000
`define SPVQ_W_SF2      17'h06000
`define SPVQ_W_SF3      17'h08000
// frequency to cosine table index
`define SPVQ_COS_MUL    16'h0029
`define SPVQ_COS_SHR    10
`define SPVQ_COS_MAX    8'hFF
`endif

// *** rtl/spvq_pkg.sv ***
package spvq_pkg;
    typedef enum logic [1:0] {
        full_rate_type             = 2'b00,
        generic_half_rate_type     = 2'b01,
        voiced_half_rate_type      = 2'b10,
        unvoiced_quarter_rate_type = 2'b11
    } spvq_type_t;
    typedef enum logic [2:0] {
        st_idle  = 3'b000,
        st_srch  = 3'b001,
        st_apply = 3'b010,
        st_fin   = 3'b011,
        st_conv  = 3'b100,
        st_intp  = 3'b101
    } spvq_state_t;
    typedef struct packed {
        logic [3:0] book;
        logic [3:0] start;
        logic [3:0] len;
        logic [3:0] bits;
    } spvq_part_t;
endpackage

// *** rtl/spvq_core.sv ***
`timescale 1ns/1ps
`include "spvq_map.svh"
// Function
// - Half-rate types split stage-two error one into elements 0-4 and 5-8, error two whole.
// - Half-rate stage two codes those parts with 7, 7 and 6 bits.
// - Quarter-rate unvoiced codes error one in two 5-bit parts and error two with 6 bits.
// - One pair of 8-bit first-stage codebooks serves the 46, 36 and 32-bit quantizers.
// - Voiced half-rate uses a first-split book variant with 28 entries replaced.
// - Each subvector takes the index with the least sum of squared differences.
// - Under autoregressive prediction the quantized error is divided by the scale.
// - Quantized vector is prediction plus residual, plus the stored mean.
// - Both predictor memories are updated every frame.
// - The quantized frequencies are converted to the cosine domain.
// - Current and previous cosine vectors are interpolated per subframe.
// - The error is scaled by 1.25 under autoregressive prediction, else unscaled.
// - The scaled error splits into nine and seven element subvectors.
// - Prediction is 1/3 of past residual, or 0.65 of past vector for voiced half-rate.
// - Initialization clears both predictor memories.
module spvq_core
    import spvq_pkg::*;
#(
    parameter int DW = 16
) (
    input  wire logic                           ref_clk,
    input  wire logic                           rstn,
    input  wire logic                           init,
    input  wire logic                           start,
    input  wire spvq_type_t                     ftype,
    input  wire logic [`SPVQ_NEL-1:0][DW-1:0]   isf_in,
    input  wire logic                           tbl_wr,
    input  wire logic [1:0]                     tbl_sel,
    input  wire logic [15:0]                    tbl_addr,
    input  wire logic [DW-1:0]                  tbl_data,
    output logic                                busy,
    output logic                                done,
    output logic [6:0][7:0]                     idx_out,
    output logic [`SPVQ_NEL-1:0][DW-1:0]        isf_quant,
    output logic [`SPVQ_NEL-1:0][DW-1:0]        isp_quant,
    output logic                                sub_valid,
    output logic [1:0]                          sub_idx,
    output logic [`SPVQ_NEL-1:0][DW-1:0]        sub_isp
);
    localparam int AW = 2 * DW + 8;
    localparam int NE = `SPVQ_NEL;

    if (DW < 12 || DW > 24) begin : g_bad_dw
        $error("spvq_core: DW must lie in 12..24");
    end

    typedef logic signed [DW-1:0] smp_t;

    // q15 product, weight taken as unsigned up to one
    function automatic smp_t qmul(input smp_t a, input logic [16:0] w);
        logic signed [DW+17:0] p;
        p = a * $signed({1'b0, w});
        return p[DW+14:15];
    endfunction

    // split layout per coding type and pass number
    function automatic spvq_part_t part_of(input spvq_type_t t, input logic [2:0] n);
        spvq_part_t r;
        r = `SPVQ_P_S1A;
        if (n == 3'h0) begin
            r = (t == voiced_half_rate_type) ? `SPVQ_P_S1V : `SPVQ_P_S1A;
        end else if (n == 3'h1) begin
            r = `SPVQ_P_S1B;
        end else begin
            unique case (t)
                full_rate_type: begin
                    unique case (n)
                        3'h2:    r = `SPVQ_P_FR0;
                        3'h3:    r = `SPVQ_P_FR1;
                        3'h4:    r = `SPVQ_P_FR2;
                        3'h5:    r = `SPVQ_P_FR3;
                        default: r = `SPVQ_P_FR4;
                    endcase
                end
                generic_half_rate_type, voiced_half_rate_type: begin
                    unique case (n)
                        3'h2:    r = `SPVQ_P_HR0;
                        3'h3:    r = `SPVQ_P_HR1;
                        default: r = `SPVQ_P_HR2;
                    endcase
                end
                unvoiced_quarter_rate_type: begin
                    unique case (n)
                        3'h2:    r = `SPVQ_P_QR0;
                        3'h3:    r = `SPVQ_P_QR1;
                        default: r = `SPVQ_P_QR2;
                    endcase
                end
            endcase
        end
        return r;
    endfunction

    smp_t        cb_mem [0:65535];
    smp_t        mean_mem [0:NE-1];
    smp_t        cos_mem [0:255];
    spvq_state_t state_q;
    spvq_type_t  type_q;
    logic [2:0]  part_q;
    logic [8:0]  ent_q;
    logic [3:0]  el_q;
    logic [1:0]  sf_q;
    logic [AW-1:0] acc_q, best_q;
    logic [7:0]  bidx_q;
    smp_t        tgt_q [NE], qs_q [NE], pred_q [NE];
    smp_t        rmem_q [NE], zmem_q [NE], prev_q [NE];

    // table loading; loads are meant for idle time, a mid-frame load changes that frame
    always_ff @(posedge ref_clk) begin
        if (tbl_wr && tbl_sel == `SPVQ_TBL_CB) cb_mem[tbl_addr] <= tbl_data;
        if (tbl_wr && tbl_sel == `SPVQ_TBL_MEAN) mean_mem[tbl_addr[3:0]] <= tbl_data;
        if (tbl_wr && tbl_sel == `SPVQ_TBL_COS) cos_mem[tbl_addr[7:0]] <= tbl_data;
    end

    // search decode
    spvq_part_t         pt;
    logic [3:0]         eabs;
    logic [7:0]         ent_sel;
    smp_t               cb_w;
    logic signed [DW:0] diff_w;
    logic signed [2*DW+1:0] prod_w;
    logic [AW-1:0]      acc_n;
    logic               last_el, last_ent, better, ar_n, ar_q, accept;
    logic [2:0]         npart;
    assign pt       = part_of(type_q, part_q);
    assign eabs     = pt.start + el_q;
    assign ent_sel  = (state_q == st_apply) ? bidx_q : ent_q[7:0];
    assign cb_w     = cb_mem[{pt.book, ent_sel, el_q}];
    assign diff_w   = {tgt_q[eabs][DW-1], tgt_q[eabs]} - {cb_w[DW-1], cb_w};
    assign prod_w   = diff_w * diff_w;
    assign acc_n    = acc_q + AW'(prod_w);
    assign last_el  = (el_q == pt.len - 4'h1);
    assign last_ent = (ent_q == (9'h001 << pt.bits) - 9'h001);
    assign better   = (ent_q == 9'h000) || (acc_n < best_q);
    assign npart    = (type_q == full_rate_type) ? `SPVQ_NPART_FR : `SPVQ_NPART_SPL;
    assign ar_n     = (ftype == voiced_half_rate_type);
    assign ar_q     = (type_q == voiced_half_rate_type);
    assign accept   = (state_q == st_idle) && start;
    assign busy     = (state_q != st_idle);

    // prediction, scaling and reconstruction per element
    smp_t z_w [NE], p_w [NE], r_w [NE], rs_w [NE], rh_w [NE], zh_w [NE];
    always_comb begin
        for (int i = 0; i < NE; i++) begin
            z_w[i]  = isf_in[i] - mean_mem[i];
            p_w[i]  = ar_n ? qmul(zmem_q[i], `SPVQ_AR_COEF)
                           : qmul(rmem_q[i], `SPVQ_MA_COEF);
            r_w[i]  = z_w[i] - p_w[i];
            rs_w[i] = ar_n ? r_w[i] + (r_w[i] >>> `SPVQ_SCALE_SHR) : r_w[i];
            rh_w[i] = ar_q ? qmul(qs_q[i], `SPVQ_INV_SCALE) : qs_q[i];
            zh_w[i] = pred_q[i] + rh_w[i];
        end
    end

    // cosine lookup: element 15 uses double phase, out-of-range clamps
    logic [DW:0]    ph_w;
    logic [DW+16:0] phm_w;
    logic [7:0]     cidx_w;
    assign ph_w   = (el_q == 4'(NE - 1)) ? {isf_quant[el_q], 1'b0} : {1'b0, isf_quant[el_q]};
    assign phm_w  = ph_w * `SPVQ_COS_MUL;
    assign cidx_w = isf_quant[el_q][DW-1] ? 8'h00
                  : (|phm_w[DW+16:`SPVQ_COS_SHR+8]) ? `SPVQ_COS_MAX
                  : phm_w[`SPVQ_COS_SHR+7:`SPVQ_COS_SHR];

    // subframe interpolation weights
    logic [16:0] wcur_w, wprv_w;
    assign wcur_w = (sf_q == 2'h0) ? `SPVQ_W_SF0 : (sf_q == 2'h1) ? `SPVQ_W_SF1
                  : (sf_q == 2'h2) ? `SPVQ_W_SF2 : `SPVQ_W_SF3;
    assign wprv_w = `SPVQ_Q15_ONE - wcur_w;

    // sequencing: one codebook element per cycle, least index wins ties
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_q   <= st_idle;
            type_q    <= full_rate_type;
            part_q    <= 3'h0;
            ent_q     <= 9'h000;
            el_q      <= 4'h0;
            sf_q      <= 2'h0;
            acc_q     <= '0;
            best_q    <= '0;
            bidx_q    <= 8'h00;
            idx_out   <= '0;
            done      <= 1'b0;
            sub_valid <= 1'b0;
            sub_idx   <= 2'h0;
        end else begin
            done      <= 1'b0;
            sub_valid <= 1'b0;
            unique case (state_q)
                st_idle: begin
                    if (start) begin
                        state_q <= st_srch;
                        type_q  <= ftype;
                        part_q  <= 3'h0;
                        ent_q   <= 9'h000;
                        el_q    <= 4'h0;
                        acc_q   <= '0;
                        idx_out <= '0;
                    end
                end
                st_srch: begin
                    if (last_el) begin
                        acc_q <= '0;
                        el_q  <= 4'h0;
                        if (better) begin
                            best_q <= acc_n;
                            bidx_q <= ent_q[7:0];
                        end
                        if (last_ent) state_q <= st_apply;
                        else ent_q <= ent_q + 9'h001;
                    end else begin
                        acc_q <= acc_n;
                        el_q  <= el_q + 4'h1;
                    end
                end
                st_apply: begin
                    if (last_el) begin
                        el_q            <= 4'h0;
                        ent_q           <= 9'h000;
                        idx_out[part_q] <= bidx_q;
                        if (part_q == npart - 3'h1) begin
                            state_q <= st_fin;
                        end else begin
                            part_q  <= part_q + 3'h1;
                            state_q <= st_srch;
                        end
                    end else begin
                        el_q <= el_q + 4'h1;
                    end
                end
                st_fin: begin
                    state_q <= st_conv;
                    el_q    <= 4'h0;
                end
                st_conv: begin
                    el_q <= el_q + 4'h1;
                    if (el_q == 4'(NE - 1)) begin
                        state_q <= st_intp;
                        sf_q    <= 2'h0;
                    end
                end
                st_intp: begin
                    sub_valid <= 1'b1;
                    sub_idx   <= sf_q;
                    sf_q      <= sf_q + 2'h1;
                    if (sf_q == 2'h3) begin
                        done    <= 1'b1;
                        state_q <= st_idle;
                    end
                end
                default: state_q <= st_idle;
            endcase
        end
    end

    // working error and quantized sum; stage two sees what stage one left
    always_ff @(posedge ref_clk) begin
        if (accept) begin
            for (int i = 0; i < NE; i++) begin
                tgt_q[i]  <= rs_w[i];
                qs_q[i]   <= '0;
                pred_q[i] <= p_w[i];
            end
        end else if (state_q == st_apply) begin
            tgt_q[eabs] <= tgt_q[eabs] - cb_w;
            qs_q[eabs]  <= qs_q[eabs] + cb_w;
        end
    end

    // predictor memories and quantized frequencies; init wins over a frame end
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < NE; i++) begin
                rmem_q[i]    <= '0;
                zmem_q[i]    <= '0;
                isf_quant[i] <= '0;
            end
        end else if (init) begin
            for (int i = 0; i < NE; i++) begin
                rmem_q[i] <= '0;
                zmem_q[i] <= '0;
            end
        end else if (state_q == st_fin) begin
            for (int i = 0; i < NE; i++) begin
                rmem_q[i]    <= rh_w[i];
                zmem_q[i]    <= zh_w[i];
                isf_quant[i] <= zh_w[i] + mean_mem[i];
            end
        end
    end

    // cosine vector, previous-frame copy and per-subframe output
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < NE; i++) begin
                isp_quant[i] <= '0;
                prev_q[i]    <= '0;
                sub_isp[i]   <= '0;
            end
        end else if (state_q == st_conv) begin
            isp_quant[el_q] <= cos_mem[cidx_w];
        end else if (state_q == st_intp) begin
            for (int i = 0; i < NE; i++) begin
                sub_isp[i] <= qmul(prev_q[i], wprv_w) + qmul(isp_quant[i], wcur_w);
                if (sf_q == 2'h3) prev_q[i] <= isp_quant[i];
            end
        end
    end

    default clocking cb_clk @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    sequence s_intp4;
        state_q == st_intp [*4];
    endsequence
    sequence s_back_idle;
        (state_q == st_idle) && done;
    endsequence

    property p_done_last_sub;
        done |-> sub_valid && (sub_idx == 2'h3) && $past(state_q == st_intp);
    endproperty
    a_done_last_sub: assert property (p_done_last_sub)
        else $error("done without last subframe");

    property p_intp_run;
        (state_q == st_conv) && (el_q == 4'hF) |=> s_intp4 ##1 s_back_idle;
    endproperty
    a_intp_run: assert property (p_intp_run)
        else $error("interpolation did not run four subframes");

    property p_hr_split;
        (state_q == st_srch) && (type_q inside {generic_half_rate_type, voiced_half_rate_type})
        && (part_q == 3'h3) |-> (pt.start == 4'h5) && (pt.len == 4'h4) && (pt.bits == 4'h7);
    endproperty
    a_hr_split: assert property (p_hr_split)
        else $error("half-rate second split wrong");

    property p_hr_bits;
        done && (type_q == generic_half_rate_type) |-> (idx_out[4][7:6] == 2'h0);
    endproperty
    a_hr_bits: assert property (p_hr_bits)
        else $error("half-rate index out of 6 bits");

    property p_qr_bits;
        done && (type_q == unvoiced_quarter_rate_type)
        |-> (idx_out[2][7:5] == 3'h0) && (idx_out[3][7:5] == 3'h0) && (idx_out[4][7:6] == 2'h0);
    endproperty
    a_qr_bits: assert property (p_qr_bits)
        else $error("quarter-rate index too wide");

    property p_book_sel;
        (state_q == st_srch) && (part_q == 3'h0) |-> (pt.book == (ar_q ? 4'h1 : 4'h0));
    endproperty
    a_book_sel: assert property (p_book_sel)
        else $error("first-split book variant misselected");

    property p_keep_best;
        (state_q == st_srch) && last_el && (ent_q != 9'h000) && (acc_n >= best_q)
        |=> (bidx_q == $past(bidx_q)) && (best_q == $past(best_q));
    endproperty
    a_keep_best: assert property (p_keep_best)
        else $error("worse candidate replaced best");

    property p_isf_mean;
        (state_q == st_fin) && !init |=> (isf_quant[0] == zmem_q[0] + mean_mem[0]);
    endproperty
    a_isf_mean: assert property (p_isf_mean)
        else $error("quantized vector not memory plus mean");

    property p_init_clear;
        init |=> (rmem_q[0] == '0) && (zmem_q[NE-1] == '0);
    endproperty
    a_init_clear: assert property (p_init_clear)
        else $error("init left predictor memory");

    property p_s1_split;
        (state_q == st_srch) && (part_q == 3'h1) |-> (pt.start == 4'h9) && (pt.len == 4'h7);
    endproperty
    a_s1_split: assert property (p_s1_split)
        else $error("first-stage second split wrong");
endmodule // spvq_core

// *** sim/spvq_lp_model.sv ***
`timescale 1ns/1ps
// upstream analysis stand-in: one vector and coding type per frame with a start pulse
module spvq_lp_model
    import spvq_pkg::*;
(
    input  wire logic          ref_clk,
    output logic               start,
    output spvq_type_t         ftype,
    output logic [15:0][15:0]  isf_in
);
    // idle levels from time zero
    initial begin
        start  = 1'b0;
        ftype  = full_rate_type;
        isf_in = '0;
    end

    // one frame request; the vector is inverted afterwards so stale data never passes
    task automatic send(input spvq_type_t t, input logic [15:0][15:0] v);
        @(negedge ref_clk);
        start  = 1'b1;
        ftype  = t;
        isf_in = v;
        @(negedge ref_clk);
        start  = 1'b0;
        isf_in = ~v;
    endtask
endmodule // spvq_lp_model

// *** sim/spectral_pair_vector_quantizer_tb_top.sv ***
`timescale 1ns/1ps
module spectral_pair_vector_quantizer_tb_top;
    import spvq_pkg::*;
    logic              ref_clk;
    logic              rstn;
    logic              init;
    logic              tbl_wr;
    logic [1:0]        tbl_sel;
    logic [15:0]       tbl_addr;
    logic [15:0]       tbl_data;
    logic              start;
    spvq_type_t        ftype;
    logic [15:0][15:0] isf_in;
    logic              busy;
    logic              done;
    logic [6:0][7:0]   idx_out;
    logic [15:0][15:0] isf_quant;
    logic [15:0][15:0] isp_quant;
    logic              sub_valid;
    logic [1:0]        sub_idx;
    logic [15:0][15:0] sub_isp;
    int                error_cnt;
    int                compares;
    // index bits per codebook, books 0..13
    int                bt [14] = '{8, 8, 8, 6, 7, 7, 5, 5, 7, 7, 6, 5, 5, 6};
    localparam logic [6:0][7:0] IX_FR = {8'h03, 8'h03, 8'h03, 8'h03, 8'h03, 8'h11, 8'h11};
    localparam logic [6:0][7:0] IX_SP = {8'h00, 8'h00, 8'h03, 8'h03, 8'h03, 8'h11, 8'h11};
    localparam logic [6:0][7:0] IX_AR = {8'h00, 8'h00, 8'h03, 8'h03, 8'h03, 8'h5A, 8'h28};

    spvq_core dut (
        .ref_clk(ref_clk), .rstn(rstn), .init(init), .start(start), .ftype(ftype),
        .isf_in(isf_in), .tbl_wr(tbl_wr), .tbl_sel(tbl_sel), .tbl_addr(tbl_addr),
        .tbl_data(tbl_data), .busy(busy), .done(done), .idx_out(idx_out),
        .isf_quant(isf_quant), .isp_quant(isp_quant), .sub_valid(sub_valid),
        .sub_idx(sub_idx), .sub_isp(sub_isp)
    );
    spvq_lp_model u_up (.ref_clk(ref_clk), .start(start), .ftype(ftype), .isf_in(isf_in));

    // 40 MHz clock
    initial ref_clk = 1'b0;
    always #12.5 ref_clk = ~ref_clk;

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("compares=%0d error_cnt=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [1:0] sel, input logic [15:0] a, input logic [15:0] d);
        @(negedge ref_clk);
        tbl_wr   = 1'b1;
        tbl_sel  = sel;
        tbl_addr = a;
        tbl_data = d;
    endtask

    // every element slot is written so no entry is left unknown
    task automatic load_book(input int b, input int ea, input int va, input int eb,
                             input int vb, input int fill);
        for (int e = 0; e < (1 << bt[b]); e++) begin
            for (int el = 0; el < 16; el++) begin
                wr(2'h0, {4'(b), 8'(e), 4'(el)},
                   (e == ea) ? 16'(va) : ((e == eb) ? 16'(vb) : 16'(fill)));
            end
        end
    endtask

    // cosine word j is j*16 so interpolation by quarters stays exact
    task automatic load_tables();
        for (int j = 0; j < 256; j++) wr(2'h2, 16'(j), 16'(j << 4));
        for (int i = 0; i < 16; i++) wr(2'h1, 16'(i), 16'h03E8);
        load_book(0, 17, 200, 17, 200, 0);
        load_book(1, 40, 250, 40, 250, 0);
        load_book(2, 17, 200, 90, 250, 0);
        for (int b = 3; b < 14; b++) load_book(b, 3, 0, 3, 0, 64);
        @(negedge ref_clk);
        tbl_wr = 1'b0;
    endtask

    function automatic logic [15:0] cosx(input int f, input int i);
        int j;
        j = ((i == 15 ? 2 * f : f) * 41) >>> 10;
        if (j > 255) j = 255;
        if (j < 0) j = 0;
        return 16'(j << 4);
    endfunction

    // cycles from the accept edge to done: stage-one passes, stage-two parts, fin,
    // conversion, subframes; the accept edge itself is not counted by run_frame
    function automatic int lat(input spvq_type_t t);
        int l;
        l = 2313 + 1799 + 1 + 16 + 4;
        case (t)
            full_rate_type: l += 195 + 387 + 387 + 99 + 132;
            unvoiced_quarter_rate_type: l += 165 + 132 + 455;
            default: l += 645 + 516 + 455;
        endcase
        return l;
    endfunction

    // one frame of z+mean; q is the expected quantized frequency of every element
    task automatic run_frame(input spvq_type_t t, input int z, input logic [6:0][7:0] ex,
                             input int q, input logic first, input logic poke);
        logic [15:0][15:0] v;
        int n;
        int s;
        for (int i = 0; i < 16; i++) v[i] = 16'(z + 1000);
        u_up.send(t, v);
        n = 0;
        s = 0;
        if (poke) begin
            repeat (3) @(negedge ref_clk);
            u_up.send(full_rate_type, '0); // refused while busy
            n = 5;
        end
        while (done !== 1'b1 && n < 20000) begin
            @(negedge ref_clk);
            n++;
            if (sub_valid === 1'b1) begin
                chk(16'(sub_idx), 16'(s));
                for (int i = 0; i < 16; i++) begin
                    if (s == 3) chk(sub_isp[i], cosx(q, i));
                    if (s == 0 && first) chk(sub_isp[i], cosx(q, i) >> 2);
                end
                s++;
            end
        end
        chk(16'(n), 16'(lat(t)));
        chk(16'(s), 16'h0004);
        for (int i = 0; i < 16; i++) begin
            if (i < 7) chk(16'(idx_out[i]), 16'(ex[i]));
            chk(isf_quant[i], 16'(q));
            chk(isp_quant[i], cosx(q, i));
        end
        @(negedge ref_clk);
        chk(16'({done, busy}), 16'h0000);
    endtask

    task automatic sc_first();
        run_frame(full_rate_type, 200, IX_FR, 1200, 1'b1, 1'b0);
    endtask
    task automatic sc_ma_pred();
        run_frame(full_rate_type, 266, IX_FR, 1266, 1'b0, 1'b1);
    endtask
    task automatic sc_ar();
        run_frame(voiced_half_rate_type, 372, IX_AR, 1371, 1'b0, 1'b0);
    endtask
    task automatic sc_quarter();
        run_frame(unvoiced_quarter_rate_type, 266, IX_SP, 1266, 1'b0, 1'b0);
    endtask
    task automatic sc_init();
        @(negedge ref_clk);
        init = 1'b1;
        @(negedge ref_clk);
        init = 1'b0;
        run_frame(generic_half_rate_type, 200, IX_SP, 1200, 1'b0, 1'b0);
    endtask

    // main sequence
    initial begin
        rstn      = 1'b0;
        init      = 1'b0;
        tbl_wr    = 1'b0;
        tbl_sel   = 2'h0;
        tbl_addr  = 16'h0000;
        tbl_data  = 16'h0000;
        error_cnt = 0;
        compares  = 0;
        repeat (16) @(negedge ref_clk);
        rstn = 1'b1;
        chk(16'({done, busy}), 16'h0000);
        load_tables();
        sc_first();
        sc_ma_pred();
        sc_ar();
        sc_quarter();
        sc_init();
        final_report();
    end

    // watchdog, well beyond table loading plus five frames
    initial begin
        #(80000 * 25);
        error_cnt++;
        $display("ERROR t=%0t watchdog seen=%h exp=%h", $time, 1'b0, 1'b1);
        final_report();
    end
endmodule // spectral_pair_vector_quantizer_tb_top
